// ===== ccs_device.sv
/*
 * configuration sequencer of one chain device: active serial read or test-port load.
 * assumes the host holds the pins per the chain wiring; pins enter through two flops, except the test-port start and stream pins, used unregistered.
 */
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`default_nettype none
module ccs_device
	import ccs_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       resetn_i,
	ccs_chain_if.dev        link,
	input  wire logic       serial_mem_data_in_i,
	output logic            serial_config_clock_o,
	output logic            serial_mem_chip_select_out_o,
	output logic            serial_mem_data_out_o,
	output logic [7:0]      cfg_data_o,
	output logic            cfg_valid_o,
	output logic            user_mode_o,
	output logic            cfg_error_o
);
	//==============================================================
	// state
	typedef struct packed {
		ccs_dev_state_type st;
		logic [1:0]        ce_s;
		logic [1:0]        done_s;
		logic [1:0]        rcfg_s;
		logic [1:0]        d0_s;
		logic [3:0]        msel_m;
		logic [3:0]        msel_s;
		logic [2:0]        div;
		logic              sclk;
		logic              cs_n;
		logic              mosi;
		logic [2:0]        bit_cnt;
		logic [7:0]        cmd_sh;
		logic [7:0]        rx_sh;
		logic [7:0]        byte_cnt;
		logic              first;
		logic              compressed;
		logic [7:0]        data;
		logic              data_valid;
		logic              ceo_n;
		logic              done_oe_n;
		logic              hlth_oe_n;
		logic              user;
	} ccs_dev_reg_type;

	localparam ccs_dev_reg_type DEV_RST = '{
		st: ST_RESET, ce_s: 2'h3, done_s: 2'h0, rcfg_s: 2'h0, d0_s: 2'h0,
		msel_m: 4'h0, msel_s: 4'h0, div: 3'h0, sclk: 1'b0, cs_n: 1'b1,
		mosi: 1'b0, bit_cnt: 3'h0, cmd_sh: 8'h00, rx_sh: 8'h00,
		byte_cnt: 8'h00, first: 1'b1, compressed: 1'b0, data: 8'h00,
		data_valid: 1'b0, ceo_n: 1'b1, done_oe_n: 1'b0, hlth_oe_n: 1'b0,
		user: 1'b0
	};

	ccs_dev_reg_type r;
	ccs_dev_reg_type next_r;
	logic            ce_low;
	logic            rcfg_high;
	logic            tick;
	logic            byte_stb;
	logic [7:0]      byte_in;
	logic            tp_take;

	//==============================================================
	// pin synchronisers
	assign ce_low    = ~r.ce_s[1];
	assign rcfg_high = r.rcfg_s[1];
	assign tick      = (r.div == SCLK_HALF - 3'h1);
	assign tp_take   = (r.st == ST_TP_LOAD) && link.tp_valid;

	always_comb
	begin
		next_r            = r;
		next_r.data_valid = 1'b0;
		byte_stb          = 1'b0;
		byte_in           = 8'h00;
		next_r.ce_s       = {r.ce_s[0], link.chain_enable_in_n};
		next_r.done_s     = {r.done_s[0], link.config_done_line};
		next_r.rcfg_s     = {r.rcfg_s[0], link.reconfig_request_n};
		next_r.d0_s       = {r.d0_s[0], serial_mem_data_in_i};
		next_r.msel_m     = link.scheme_select;
		next_r.msel_s     = r.msel_m;
		next_r.div        = tick ? 3'h0 : r.div + 3'h1;

		if (!rcfg_high)
		begin
			next_r.st        = ST_RESET;
			next_r.cs_n      = 1'b1;
			next_r.sclk      = 1'b0;
			next_r.ceo_n     = 1'b1;
			next_r.done_oe_n = 1'b0;
			next_r.hlth_oe_n = 1'b0;
			next_r.user      = 1'b0;
			next_r.first     = 1'b1;
		end
		else
		begin
			case (r.st)
			ST_RESET:
			begin
				next_r.hlth_oe_n = 1'b1;
				next_r.st        = ST_WAIT;
			end
			ST_WAIT:
			begin
				if (ce_low && link.tp_start) // RULE_14
				begin
					next_r.st    = ST_TP_LOAD;
					next_r.first = 1'b1;
				end
				else if (ce_low && r.msel_s == SCHEME_AS) // RULE_02
				begin
					next_r.st       = ST_AS_CMD;
					next_r.cs_n     = 1'b0; // RULE_11
					next_r.cmd_sh   = AS_READ_CMD;
					next_r.mosi     = AS_READ_CMD[7];
					next_r.bit_cnt  = 3'h0;
					next_r.byte_cnt = 8'h00;
					next_r.first    = 1'b1;
					next_r.div      = 3'h0;
					next_r.sclk     = 1'b0;
				end
			end
			ST_AS_CMD, ST_AS_READ:
			begin
				if (ce_low && link.tp_start) // RULE_08
				begin
					next_r.st    = ST_TP_LOAD;
					next_r.cs_n  = 1'b1;
					next_r.sclk  = 1'b0;
					next_r.first = 1'b1;
				end
				else if (tick)
				begin
					next_r.sclk = ~r.sclk;
					if (!r.sclk)
					begin
						next_r.bit_cnt = r.bit_cnt + 3'h1;
						if (r.st == ST_AS_CMD)
						begin
							if (r.bit_cnt == 3'h7)
								next_r.st = ST_AS_READ;
						end
						else
						begin
							next_r.rx_sh = {r.rx_sh[6:0], r.d0_s[1]};
							if (r.bit_cnt == 3'h7)
							begin
								byte_stb        = 1'b1;
								byte_in         = {r.rx_sh[6:0], r.d0_s[1]};
								next_r.byte_cnt = r.byte_cnt + 8'h01;
								if (r.byte_cnt == AS_BYTES - 8'h01)
								begin
									next_r.st   = ST_RELEASE;
									next_r.cs_n = 1'b1;
								end
							end
						end
					end
					else if (r.st == ST_AS_CMD)
					begin
						next_r.cmd_sh = {r.cmd_sh[6:0], 1'b0};
						next_r.mosi   = r.cmd_sh[6]; // RULE_11
					end
				end
			end
			ST_TP_LOAD:
			begin
				if (tp_take)
				begin
					byte_stb = 1'b1;
					byte_in  = link.tp_data;
					if (link.tp_last)
						next_r.st = ST_RELEASE;
				end
			end
			ST_RELEASE:
			begin
				next_r.sclk      = 1'b0;
				next_r.done_oe_n = 1'b1; // RULE_13
				next_r.ceo_n     = 1'b0; // RULE_03
				if (r.done_s[1]) // RULE_05
				begin
					next_r.st   = ST_USER;
					next_r.user = 1'b1;
				end
			end
			ST_USER, ST_ERROR:
			begin
				next_r.st = r.st;
			end
			default:
			begin
				next_r.st = ST_RESET;
			end
			endcase

			//==============================================================
			// header byte carries the compression flag
			if (byte_stb)
			begin
				if (r.first)
				begin
					next_r.first      = 1'b0;
					next_r.compressed = byte_in[HDR_COMP_BIT];
					if (r.st == ST_TP_LOAD && byte_in[HDR_COMP_BIT]) // RULE_09
					begin
						next_r.st        = ST_ERROR;
						next_r.hlth_oe_n = 1'b0;
					end
				end
				else
				begin
					next_r.data       = byte_in;
					next_r.data_valid = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			r <= DEV_RST;
		else
			r <= next_r;
	end

	//==============================================================
	// outputs
	assign link.tp_ready                = (r.st == ST_TP_LOAD);
	assign link.chain_enable_out_n      = r.ceo_n;
	assign link.done_o                  = 1'b0;
	assign link.done_oe_n               = r.done_oe_n;
	assign link.health_o                = 1'b0;
	assign link.health_oe_n             = r.hlth_oe_n;
	assign serial_config_clock_o        = r.sclk;
	assign serial_mem_chip_select_out_o = r.cs_n;
	assign serial_mem_data_out_o        = r.mosi;
	assign cfg_data_o                   = r.data;
	assign cfg_valid_o                  = r.data_valid;
	assign user_mode_o                  = r.user;
	assign cfg_error_o                  = (r.st == ST_ERROR);
endmodule
`default_nettype wire

// ===== ccs_pkg.sv
/*
 * constants and state types shared by both ends of the configuration chain.
 * assumes one 250 MHz clock and an active-low asynchronous reset at each end.
 */
//==============================================================
// What this block does
// RULE_01: host holds chain enable low during test-port load
// RULE_02: chain enable in low starts, output feeds next
// RULE_03: configured device drives chain enable output low
// RULE_04: host configures over test port in chain order
// RULE_05: shared done line releases devices into user together
// RULE_06: host configures every device on shared done lines
// RULE_07: isolated done lines let devices start individually
// RULE_08: test-port load aborts active-serial load
// RULE_09: no decompression on test port; compressed rejected
// RULE_10: test-port only: reconfig high, scheme select low
// RULE_11: active serial drives memory select and data out
// RULE_12: host selects active-serial scheme when combining
// RULE_13: successful test-port load releases done line high
// RULE_14: chain enable input high blocks any load start
`default_nettype none
package ccs_pkg;
	//==============================================================
	// scheme select codes
	localparam logic [3:0] SCHEME_NONE = 4'h0;
	localparam logic [3:0] SCHEME_AS   = 4'h2;
	//==============================================================
	// active serial memory access
	localparam logic [7:0] AS_READ_CMD  = 8'h03;
	localparam logic [7:0] AS_BYTES     = 8'h10;
	localparam int         SCLK_HALF_NS = 12;
	localparam int         CLK_NS       = 4;
	localparam logic [2:0] SCLK_HALF    = 3'((SCLK_HALF_NS + CLK_NS - 1) / CLK_NS);
	localparam int         HDR_COMP_BIT = 0;
	//==============================================================
	// host register map
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_DATA    = 8'h04;
	localparam logic [7:0] REG_STATUS  = 8'h08;
	localparam int         CTRL_RUN    = 0;
	localparam int         CTRL_HOLDCE = 1;
	localparam int         CTRL_MSEL   = 4;
	localparam int         CTRL_START  = 8;
	localparam int         DATA_LAST   = 8;
	localparam logic       RST_RUN     = 1'b0;
	localparam logic       RST_HOLDCE  = 1'b1;
	localparam logic [3:0] RST_MSEL    = 4'h0;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	//==============================================================
	typedef enum logic [2:0] {
		ST_RESET, ST_WAIT, ST_AS_CMD, ST_AS_READ, ST_TP_LOAD, ST_RELEASE, ST_USER, ST_ERROR
	} ccs_dev_state_type;
endpackage
`default_nettype wire

// ===== ccs_chain_if.sv
/*
 * pins between a chain device and its download host.
 * assumes pull-ups on done and health; resolved here from the device enables.
 */
`default_nettype none
interface ccs_chain_if;
	logic       reconfig_request_n;
	logic [3:0] scheme_select;
	logic       chain_enable_in_n;
	logic       chain_enable_out_n;
	logic       done_o;
	logic       done_oe_n;
	logic       health_o;
	logic       health_oe_n;
	logic       config_done_line;
	logic       config_health_n;
	logic       tp_start;
	logic       tp_valid;
	logic       tp_ready;
	logic [7:0] tp_data;
	logic       tp_last;

	//==============================================================
	// open-drain resolution with pull-ups
	assign config_done_line = done_oe_n ? 1'b1 : done_o; // RULE_07
	assign config_health_n  = health_oe_n ? 1'b1 : health_o;

	modport dev (
		input  reconfig_request_n, scheme_select, chain_enable_in_n,
		input  config_done_line, config_health_n,
		input  tp_start, tp_valid, tp_data, tp_last,
		output chain_enable_out_n, done_o, done_oe_n, health_o, health_oe_n, tp_ready
	);
	modport host (
		output reconfig_request_n, scheme_select, chain_enable_in_n,
		output tp_start, tp_valid, tp_data, tp_last,
		input  chain_enable_out_n, config_done_line, config_health_n, tp_ready
	);
endinterface
`default_nettype wire

// ===== ccs_host.sv
/*
 * download host: AXI4-Lite register slave that drives the chain pins and test-port stream.
 * assumes software sets run, chain hold and scheme select before loading bytes.
 */
`default_nettype none
module ccs_host
	import ccs_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	ccs_chain_if.host        link,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp
);
	typedef struct packed {
		logic        aw_got;
		logic [7:0]  aw_addr;
		logic        w_got;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        run;
		logic        hold_ce;
		logic [3:0]  msel;
		logic        start;
		logic        tp_full;
		logic [7:0]  tp_data;
		logic        tp_last;
		logic [1:0]  done_s;
		logic [1:0]  hlth_s;
		logic [1:0]  ceo_s;
	} ccs_host_reg_type;

	localparam ccs_host_reg_type HOST_RST = '{
		aw_got: 1'b0, aw_addr: 8'h00, w_got: 1'b0, w_data: 32'h0000_0000,
		w_strb: 4'h0, bvalid: 1'b0, bresp: RESP_OKAY, rvalid: 1'b0,
		rdata: 32'h0000_0000, rresp: RESP_OKAY, run: RST_RUN,
		hold_ce: RST_HOLDCE, msel: RST_MSEL, start: 1'b0, tp_full: 1'b0,
		tp_data: 8'h00, tp_last: 1'b0, done_s: 2'h0, hlth_s: 2'h0, ceo_s: 2'h3
	};

	ccs_host_reg_type r;
	ccs_host_reg_type next_r;

	always_comb
	begin
		next_r        = r;
		next_r.start  = 1'b0;
		next_r.done_s = {r.done_s[0], link.config_done_line};
		next_r.hlth_s = {r.hlth_s[0], link.config_health_n};
		next_r.ceo_s  = {r.ceo_s[0], link.chain_enable_out_n};
		if (r.tp_full && link.tp_ready)
			next_r.tp_full = 1'b0;
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_r.aw_got  = 1'b1;
			next_r.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_r.w_got  = 1'b1;
			next_r.w_data = s_axi_wdata;
			next_r.w_strb = s_axi_wstrb;
		end
		// response clear first, so a new response wins
		if (r.bvalid && s_axi_bready)
			next_r.bvalid = 1'b0;
		//==============================================================
		// write commit; a full stream slot stalls the response
		if (r.aw_got && r.w_got && !(r.aw_addr == REG_DATA && r.tp_full))
		begin
			next_r.aw_got = 1'b0;
			next_r.w_got  = 1'b0;
			next_r.bvalid = 1'b1;
			next_r.bresp  = RESP_OKAY;
			if (r.aw_addr == REG_CTRL)
			begin
				if (r.w_strb[0])
				begin
					next_r.run     = r.w_data[CTRL_RUN];
					next_r.hold_ce = r.w_data[CTRL_HOLDCE];
					next_r.msel    = r.w_data[CTRL_MSEL +: 4];
				end
				if (r.w_strb[1])
					next_r.start = r.w_data[CTRL_START];
			end
			else if (r.aw_addr == REG_DATA)
			begin
				next_r.tp_full = 1'b1;
				next_r.tp_data = r.w_data[7:0];
				next_r.tp_last = r.w_data[DATA_LAST];
			end
			else if (r.aw_addr != REG_STATUS)
			begin
				next_r.bresp = RESP_SLVERR;
			end
		end
		//==============================================================
		// read
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_r.rvalid = 1'b1;
			next_r.rresp  = RESP_OKAY;
			next_r.rdata  = 32'h0000_0000;
			if (s_axi_araddr == REG_CTRL)
				next_r.rdata = {24'h000000, r.msel, 2'h0, r.hold_ce, r.run};
			else if (s_axi_araddr == REG_STATUS)
				next_r.rdata = {28'h0000000, r.tp_full, r.ceo_s[1], r.hlth_s[1], r.done_s[1]};
			else if (s_axi_araddr != REG_DATA)
				next_r.rresp = RESP_SLVERR;
		end
		else if (r.rvalid && s_axi_rready)
		begin
			next_r.rvalid = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			r <= HOST_RST;
		else
			r <= next_r;
	end

	assign s_axi_awready           = ~r.aw_got;
	assign s_axi_wready            = ~r.w_got;
	assign s_axi_bvalid            = r.bvalid;
	assign s_axi_bresp             = r.bresp;
	assign s_axi_arready           = ~r.rvalid;
	assign s_axi_rvalid            = r.rvalid;
	assign s_axi_rdata             = r.rdata;
	assign s_axi_rresp             = r.rresp;
	assign link.reconfig_request_n = r.run; // RULE_10
	assign link.chain_enable_in_n  = ~r.hold_ce; // RULE_01
	assign link.scheme_select      = r.msel; // RULE_12
	assign link.tp_start           = r.start; // RULE_04
	assign link.tp_valid           = r.tp_full;
	assign link.tp_data            = r.tp_data;
	assign link.tp_last            = r.tp_last;
endmodule
`default_nettype wire

// ===== ccs_chain_props.sv
/*
 * checker: timing relations on the chain interface between host and device.
 * assumes it is instantiated beside the interface, one clock domain.
 */
`default_nettype none
module ccs_chain_props
(
	input wire logic       clk_i,
	input wire logic       resetn_i,
	input wire logic       reconfig_request_n,
	input wire logic       chain_enable_in_n,
	input wire logic       chain_enable_out_n,
	input wire logic       done_oe_n,
	input wire logic       health_oe_n,
	input wire logic       config_done_line,
	input wire logic       tp_start,
	input wire logic       tp_valid,
	input wire logic       tp_ready,
	input wire logic [7:0] tp_data,
	input wire logic       tp_last
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);
	//==============================================================
	// sequences
	sequence recfg_rise_s;
		$rose(reconfig_request_n);
	endsequence
	sequence last_take_s;
		tp_valid && tp_ready && tp_last;
	endsequence
	//==============================================================
	// assertions
	ready_ce_high_a: assert property ((chain_enable_in_n[*3] ##0 !tp_ready) |=> !tp_ready)
		else $error("load started while chain enable high");
	ready_ce_low_a: assert property (tp_ready |-> !chain_enable_in_n)
		else $error("chain enable high during test-port load");
	ceo_done_a: assert property (!chain_enable_out_n |-> config_done_line && done_oe_n)
		else $error("chain enable out low without done released");
	reset_lines_a: assert property (!reconfig_request_n[*4] |-> !done_oe_n && !health_oe_n && chain_enable_out_n)
		else $error("lines not held during reconfigure");
	health_release_a: assert property (recfg_rise_s |-> ##[1:8] health_oe_n)
		else $error("health not released after reconfigure");
	load_exit_a: assert property (last_take_s |-> ##[1:2] (done_oe_n && !chain_enable_out_n))
		else $error("done or chain enable out late after last byte");
	tp_hold_a: assert property (tp_valid && !tp_ready |=> tp_valid && $stable(tp_data) && $stable(tp_last))
		else $error("stream byte changed before taken");
	start_pulse_a: assert property (tp_start |=> !tp_start)
		else $error("start longer than one cycle");
endmodule
`default_nettype wire

// ===== config_chain_sequencing_tb.sv
/*
 * bench: host and device joined by the chain interface, driven over AXI4-Lite.
 * assumes a 250 MHz clock; the bench plays the serial memory pin.
 */
`default_nettype none
module config_chain_sequencing_tb;
	import ccs_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i = 1'b0;
	logic        resetn_i = 1'b0;
	logic        aw_v = 1'b0;
	logic        w_v = 1'b0;
	logic        b_rdy = 1'b0;
	logic        ar_v = 1'b0;
	logic        r_rdy = 1'b0;
	logic [7:0]  aw_a = 8'h00;
	logic [7:0]  ar_a = 8'h00;
	logic [31:0] w_d = 32'h0;
	logic [3:0]  w_s = 4'h0;
	logic        aw_r, w_r, b_v, ar_r, r_v, sclk, cs, mosi, cfg_v, user, cfg_err;
	logic        mem_din = 1'b0;
	int          mem_rise = 0;
	logic [7:0]  mem_byte = 8'h00;
	logic        sclk_q = 1'b0;
	logic [1:0]  b_resp, r_resp, rsp;
	logic [31:0] r_d, st;
	logic [7:0]  cfg_d, cmd;
	logic [7:0]  exp_q[$];
	int          bad_count = 0;
	int          num_checks = 0;
	int          cyc = 0;
	always #2 clk_i = ~clk_i;
	ccs_chain_if chain_link();
	ccs_host ccs_host_inst (.clk_i(clk_i), .resetn_i(resetn_i), .link(chain_link),
		.s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_awaddr(aw_a), .s_axi_wvalid(w_v),
		.s_axi_wready(w_r), .s_axi_wdata(w_d), .s_axi_wstrb(w_s), .s_axi_bvalid(b_v),
		.s_axi_bready(b_rdy), .s_axi_bresp(b_resp), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
		.s_axi_araddr(ar_a), .s_axi_rvalid(r_v), .s_axi_rready(r_rdy), .s_axi_rdata(r_d),
		.s_axi_rresp(r_resp));
	ccs_device ccs_device_inst (.clk_i(clk_i), .resetn_i(resetn_i), .link(chain_link),
		.serial_mem_data_in_i(mem_din), .serial_config_clock_o(sclk),
		.serial_mem_chip_select_out_o(cs), .serial_mem_data_out_o(mosi), .cfg_data_o(cfg_d),
		.cfg_valid_o(cfg_v), .user_mode_o(user), .cfg_error_o(cfg_err));
	ccs_chain_props ccs_chain_props_inst (.clk_i(clk_i), .resetn_i(resetn_i),
		.reconfig_request_n(chain_link.reconfig_request_n), .chain_enable_in_n(chain_link.chain_enable_in_n),
		.chain_enable_out_n(chain_link.chain_enable_out_n), .done_oe_n(chain_link.done_oe_n),
		.health_oe_n(chain_link.health_oe_n), .config_done_line(chain_link.config_done_line),
		.tp_start(chain_link.tp_start), .tp_valid(chain_link.tp_valid), .tp_ready(chain_link.tp_ready),
		.tp_data(chain_link.tp_data), .tp_last(chain_link.tp_last));
	//==============================================================
	// memory model: byte n reads 8'h40 + n, msb first, after the 8-bit command;
	// next bit set just after each rising serial clock; inverts each cycle when deselected
	always @(posedge clk_i)
	begin
		sclk_q <= sclk;
		if (cs)
		begin
			mem_rise <= 0;
			mem_din  <= ~mem_din;
		end
		else if (!sclk_q && sclk)
		begin
			mem_rise <= mem_rise + 1;
			mem_byte = 8'h40 + 8'((mem_rise - 7) / 8);
			if (mem_rise >= 7)
				mem_din <= mem_byte[7 - ((mem_rise - 7) % 8)];
		end
	end
	//==============================================================
	// checks, stream monitor, timeout
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	always @(posedge clk_i)
		if (resetn_i && cfg_v === 1'b1)
			chk({24'h0, cfg_d}, (exp_q.size() > 0) ? {24'h0, exp_q.pop_front()} : 32'hFFFF_FFFF);
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			test_done();
		end
	end
	task automatic test_done();
		$display("checks=%0d mismatches=%0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	//==============================================================
	// AXI4-Lite master
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk_i);
		aw_a <= a;
		w_d <= d;
		w_s <= s;
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_rdy <= 1'b1;
		forever
		begin
			@(posedge clk_i);
			if (aw_v && aw_r)
				aw_v <= 1'b0;
			if (w_v && w_r)
				w_v <= 1'b0;
			if (b_v === 1'b1)
			begin
				rsp = b_resp;
				b_rdy <= 1'b0;
				break;
			end
		end
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_i);
		ar_a <= a;
		ar_v <= 1'b1;
		r_rdy <= 1'b1;
		forever
		begin
			@(posedge clk_i);
			if (ar_v && ar_r)
				ar_v <= 1'b0;
			if (r_v === 1'b1)
			begin
				st = r_d;
				rsp = r_resp;
				r_rdy <= 1'b0;
				break;
			end
		end
	endtask
	task automatic wait_done();
		for (int i = 0; i < 400; i++)
		begin
			rd(REG_STATUS);
			if (st[0] === 1'b1)
				break;
		end
	endtask
	//==============================================================
	// main sequence
	initial
	begin
		repeat (12) @(posedge clk_i);
		resetn_i <= 1'b1;
		rd(REG_CTRL);
		chk(st, 32'h2);
		rd(REG_STATUS);
		chk(st, 32'h4);
		rd(8'h0C);
		chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
		wr(8'h0C, 32'h1, 4'hF);
		chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
		wr(REG_CTRL, 32'h01, 4'h1);
		repeat (10) @(posedge clk_i);
		wr(REG_CTRL, 32'h101, 4'h3);
		repeat (10) @(posedge clk_i);
		chk({31'h0, chain_link.tp_ready}, 32'h0);
		rd(REG_STATUS);
		chk(st, 32'h6);
		wr(REG_CTRL, 32'h03, 4'h1);
		repeat (5) @(posedge clk_i);
		wr(REG_CTRL, 32'h103, 4'h3);
		wr(REG_DATA, 32'h00, 4'hF);
		for (int k = 0; k < 4; k++)
		begin
			exp_q.push_back(8'hA0 + 8'(k));
			wr(REG_DATA, {23'h0, k == 3, 8'hA0 + 8'(k)}, 4'hF);
		end
		wait_done();
		repeat (5) @(posedge clk_i);
		rd(REG_STATUS);
		chk(st, 32'h3);
		chk({31'h0, user}, 32'h1);
		wr(REG_CTRL, 32'h02, 4'h1);
		repeat (8) @(posedge clk_i);
		wr(REG_CTRL, 32'h03, 4'h1);
		repeat (8) @(posedge clk_i);
		wr(REG_CTRL, 32'h103, 4'h3);
		wr(REG_DATA, 32'h01, 4'hF);
		repeat (8) @(posedge clk_i);
		chk({31'h0, cfg_err}, 32'h1);
		rd(REG_STATUS);
		chk(st & 32'h3, 32'h0);
		wr(REG_CTRL, 32'h02, 4'h1);
		repeat (8) @(posedge clk_i);
		wr(REG_CTRL, 32'h23, 4'h1);
		for (int i = 0; i < 8; i++)
		begin
			@(posedge sclk);
			cmd = {cmd[6:0], mosi};
		end
		chk({31'h0, cs}, 32'h0);
		chk({24'h0, cmd}, {24'h0, AS_READ_CMD});
		wr(REG_CTRL, 32'h123, 4'h3);
		repeat (4) @(posedge clk_i);
		chk({30'h0, cs, sclk}, 32'h2);
		exp_q.push_back(8'h5A);
		wr(REG_DATA, 32'h00, 4'hF);
		wr(REG_DATA, 32'h15A, 4'hF);
		wait_done();
		chk({29'h0, st[2:0]}, 32'h3);
		chk({31'h0, user}, 32'h1);
		wr(REG_CTRL, 32'h22, 4'h1);
		repeat (8) @(posedge clk_i);
		for (int j = 1; j < 16; j++)
			exp_q.push_back(8'h40 + 8'(j));
		wr(REG_CTRL, 32'h23, 4'h1);
		wait_done();
		repeat (5) @(posedge clk_i);
		rd(REG_STATUS);
		chk(st, 32'h3);
		chk({30'h0, cs, user}, 32'h3);
		chk(32'(exp_q.size()), 32'h0);
		test_done();
	end
endmodule
`default_nettype wire
